// [cprs_core_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cprs_core_if;
   logic traceEvery;
   logic traceFlow;
   logic superv;
   logic [2:0] source_space_select;
   logic [2:0] dfc;
   logic instrDone;
   logic flowInstr;
   logic cycReq;
   logic cycProg;
   logic cycAlt;
   logic cycDst;
   logic traceTrap;
   logic [2:0] spaceCode;

   modport regs (output traceEvery, traceFlow, superv, source_space_select, dfc, instrDone, flowInstr,
                 cycReq, cycProg, cycAlt, cycDst, input traceTrap, spaceCode);
   modport unit (input traceEvery, traceFlow, superv, source_space_select, dfc, instrDone, flowInstr,
                 cycReq, cycProg, cycAlt, cycDst, output traceTrap, spaceCode);
endinterface
`default_nettype wire

// [cprs_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Memory side: judges each bus cycle by its space code
// ---------------------------------------------------------------
module cprs_mem_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic cycReq,
   input wire logic [2:0] spaceCode,
   input wire logic supArea,
   output logic refuse_q
);
   logic reqSeen_q;

   // The code settles one cycle after the request, so it is judged then
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reqSeen_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         reqSeen_q <= cycReq;
         if (reqSeen_q) begin
            refuse_q <= supArea & ~spaceCode[2];
         end
      end
   end
endmodule
`default_nettype wire

// [cprs_pkg.sv]
`default_nettype none
package cprs_pkg;

   // ---------------------------------------------------------------
   // Register map, byte addresses on the APB side
   // ---------------------------------------------------------------
   localparam int unsigned CPRS_ADDR_W = 8;
   localparam logic [7:0] OFF_GPR = 8'h00;
   localparam logic [7:0] OFF_PSW = 8'h40;
   localparam logic [7:0] OFF_USP = 8'h44;
   localparam logic [7:0] OFF_ISP = 8'h48;
   localparam logic [7:0] OFF_MSP = 8'h4c;
   localparam logic [7:0] OFF_VBR = 8'h50;
   localparam logic [7:0] OFF_SFC = 8'h54;
   localparam logic [7:0] OFF_DFC = 8'h58;
   localparam logic [7:0] OFF_ICTL = 8'h5c;
   localparam logic [7:0] OFF_IADR = 8'h60;
   localparam logic [7:0] OFF_IST = 8'h64;
   localparam logic [7:0] OFF_IMASK = 8'h68;

   // ---------------------------------------------------------------
   // Status word layout and reset value
   // ---------------------------------------------------------------
   localparam int unsigned PSW_T1 = 15;
   localparam int unsigned PSW_T0 = 14;
   localparam int unsigned PSW_S = 13;
   localparam int unsigned PSW_M = 12;
   localparam int unsigned PSW_IPM = 8;
   localparam logic [15:0] PSW_RST = 16'h2700;
   localparam logic [15:0] PSW_IMPL = 16'hf71f;

   // ---------------------------------------------------------------
   // Register indices, sizes, events, space codes
   // ---------------------------------------------------------------
   localparam logic [3:0] SP_IDX = 4'hf;
   localparam logic [3:0] LAST_DATA = 4'h7;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_TRACE = 0;
   localparam int unsigned IRQ_SIZE = 1;
   localparam logic [2:0] SPC_USER_DATA = 3'h1;
   localparam logic [2:0] SPC_USER_PROG = 3'h2;
   localparam logic [2:0] SPC_SUP_DATA = 3'h5;
   localparam logic [2:0] SPC_SUP_PROG = 3'h6;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10,
      SZ_QUAD = 2'b11
   } cprs_size_e;

endpackage
`default_nettype wire

// [cprs_regset.sv]
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - any of sixteen registers indexes addresses
// - data registers: bits, fields, byte..quad
// - address registers take word or long only
// - sixteen-bit status word with priority mask
// - five condition flags updated by results
// - trace, supervisor and master bits held
// - trace bit traps after every instruction
// - flow trace traps after flow changes
// - vector table located from base register
// - every bus cycle drives space code
// - source/destination alternate space registers
// - cache control and address registers
// - user, interrupt, master stack pointers
module cprs_regset
   import cprs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CPRS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wrEn,
   input wire logic [3:0] wrIdx,
   input wire logic [1:0] wrSize,
   input wire logic [63:0] wrData,
   input wire logic bfEn,
   input wire logic [2:0] bfIdx,
   input wire logic [4:0] bfOff,
   input wire logic [4:0] bfWid,
   input wire logic [31:0] bfData,
   input wire logic ccEn,
   input wire logic [4:0] ccIn,
   input wire logic [3:0] rdIdx,
   output logic [31:0] rdData,
   input wire logic [3:0] ixIdx,
   input wire logic ixLong,
   input wire logic [1:0] ixScale,
   output logic [31:0] ixValue,
   input wire logic [7:0] vecNum,
   output logic [31:0] vecAddr,
   input wire logic instrDone,
   input wire logic flowInstr,
   input wire logic cycReq,
   input wire logic cycProg,
   input wire logic cycAlt,
   input wire logic cycDst,
   output logic [2:0] spaceCodeLines,
   output logic traceTrap,
   output logic supervisor,
   output logic [2:0] intPrioMask,
   output logic [31:0] icacheCtl,
   output logic [31:0] icacheAddr,
   output logic irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [14:0][31:0] gpr;
      logic [31:0] usp;
      logic [31:0] isp;
      logic [31:0] msp;
      logic [15:0] psw;
      logic [31:0] vbr;
      logic [2:0] source_space_select;
      logic [2:0] dfc;
      logic [31:0] ictl;
      logic [31:0] iadr;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] imask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [31:0] rdData;
      logic [31:0] ixValue;
      logic [31:0] vecAddr;
      logic irq;
   } cprs_state_s;

   cprs_state_s q;
   cprs_state_s n;
   cprs_size_e wSz;
   logic [31:0] cur;
   logic [31:0] ixRaw;
   logic [31:0] bfMask;
   logic [3:0] hiIdx;
   logic sizeEvt;
   logic apbAcc;
   logic wrTake;
   logic pswWrTake;
   logic [32:0] rdMux;

   cprs_core_if ifc();

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Index fifteen is the stack pointer picked by the status word
   function automatic logic [31:0] getReg(cprs_state_s s, logic [3:0] i);
      logic [31:0] r;
      if (i != SP_IDX) begin
         r = s.gpr[i];
      end else if (!s.psw[PSW_S]) begin
         r = s.usp;
      end else if (s.psw[PSW_M]) begin
         r = s.msp;
      end else begin
         r = s.isp;
      end
      return r;
   endfunction

   function automatic cprs_state_s putReg(cprs_state_s s, logic [3:0] i, logic [31:0] v);
      cprs_state_s r;
      r = s;
      if (i != SP_IDX) begin
         r.gpr[i] = v;
      end else if (!s.psw[PSW_S]) begin
         r.usp = v;
      end else if (s.psw[PSW_M]) begin
         r.msp = v;
      end else begin
         r.isp = v;
      end
      return r;
   endfunction

   function automatic logic [31:0] rotl(logic [31:0] x, logic [4:0] sh);
      logic [63:0] t;
      t = {x, x} << sh;
      return t[63:32];
   endfunction

   // Read decode; upper bit flags an unmapped or unaligned address
   function automatic logic [32:0] decodeRd(cprs_state_s s, logic [7:0] a);
      logic [32:0] r;
      r = {1'b0, 32'h0};
      unique case (a)
         OFF_PSW: r[15:0] = s.psw;
         OFF_USP: r[31:0] = s.usp;
         OFF_ISP: r[31:0] = s.isp;
         OFF_MSP: r[31:0] = s.msp;
         OFF_VBR: r[31:0] = s.vbr;
         OFF_SFC: r[2:0] = s.source_space_select;
         OFF_DFC: r[2:0] = s.dfc;
         OFF_ICTL: r[31:0] = s.ictl;
         OFF_IADR: r[31:0] = s.iadr;
         OFF_IST: r[IRQ_W-1:0] = s.ist;
         OFF_IMASK: r[IRQ_W-1:0] = s.imask;
         default: begin
            if (a < OFF_PSW && a[1:0] == 2'b00) begin
               r[31:0] = getReg(s, a[5:2]);
            end else begin
               r[32] = 1'b1;
            end
         end
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // APB qualifiers
   // ---------------------------------------------------------------
   // One wait state: read data is captured with pready; write data one cycle after pready shows
   assign apbAcc = psel && penable;
   assign wrTake = apbAcc && q.pready && pwrite && !q.pslverr;
   assign pswWrTake = wrTake && paddr == OFF_PSW;
   assign rdMux = decodeRd(q, paddr);
   assign hiIdx = wrIdx + 4'h1;
   assign wSz = cprs_size_e'(wrSize);
   assign cur = getReg(q, wrIdx);
   assign ixRaw = getReg(q, ixIdx);
   assign bfMask = rotl((bfWid == 5'h0) ? 32'hffffffff : ((32'h1 << bfWid) - 32'h1), bfOff);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      sizeEvt = 1'b0;
      // Core register writes
      if (wrEn && !wrIdx[3]) begin
         unique case (wSz)
            SZ_BYTE: n = putReg(n, wrIdx, {cur[31:8], wrData[7:0]});
            SZ_WORD: n = putReg(n, wrIdx, {cur[31:16], wrData[15:0]});
            SZ_LONG: n = putReg(n, wrIdx, wrData[31:0]);
            SZ_QUAD: begin
               // Pair runs low word first; the last data register has no partner
               if (wrIdx != LAST_DATA) begin
                  n.gpr[wrIdx] = wrData[31:0];
                  n.gpr[hiIdx] = wrData[63:32];
               end else begin
                  sizeEvt = 1'b1;
               end
            end
         endcase
      end else if (wrEn) begin
         unique case (wSz)
            SZ_WORD: n = putReg(n, wrIdx, {{16{wrData[15]}}, wrData[15:0]});
            SZ_LONG: n = putReg(n, wrIdx, wrData[31:0]);
            SZ_BYTE, SZ_QUAD: sizeEvt = 1'b1;
         endcase
      end
      // Bit field insert; width zero means the full 32 bits, one a single bit
      if (bfEn) begin
         n.gpr[bfIdx] = (n.gpr[bfIdx] & ~bfMask) | (rotl(bfData, bfOff) & bfMask);
      end
      // Condition flags from instruction results
      if (ccEn) begin
         n.psw[4:0] = ccIn;
      end
      // Core-side read, index and vector address ports
      n.rdData = getReg(q, rdIdx);
      n.ixValue = (ixLong ? ixRaw : {{16{ixRaw[15]}}, ixRaw[15:0]}) << ixScale;
      n.vecAddr = q.vbr + {22'h0, vecNum, 2'b00};
      // APB answer one cycle into the access phase
      n.pready = apbAcc && !q.pready;
      n.pslverr = 1'b0;
      if (apbAcc && !q.pready) begin
         n.prdata = pwrite ? 32'h0 : rdMux[31:0];
         n.pslverr = rdMux[32];
      end
      // Software writes override a core write in the same cycle
      if (wrTake) begin
         unique case (paddr)
            OFF_PSW: n.psw = pwdata[15:0] & PSW_IMPL;
            OFF_USP: n.usp = pwdata;
            OFF_ISP: n.isp = pwdata;
            OFF_MSP: n.msp = pwdata;
            OFF_VBR: n.vbr = pwdata;
            OFF_SFC: n.source_space_select = pwdata[2:0];
            OFF_DFC: n.dfc = pwdata[2:0];
            OFF_ICTL: n.ictl = pwdata;
            OFF_IADR: n.iadr = pwdata;
            OFF_IST: n.ist = q.ist & ~pwdata[IRQ_W-1:0];
            OFF_IMASK: n.imask = pwdata[IRQ_W-1:0];
            default: n = putReg(n, paddr[5:2], pwdata);
         endcase
      end
      // Events set after the clear, so a coinciding event survives
      n.ist[IRQ_SIZE] = n.ist[IRQ_SIZE] | sizeEvt;
      n.ist[IRQ_TRACE] = n.ist[IRQ_TRACE] | ifc.traceTrap;
      n.irq = |(n.ist & n.imask);
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.psw <= PSW_RST;
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------------------------
   // Trace and space code unit
   // ---------------------------------------------------------------
   assign ifc.traceEvery = q.psw[PSW_T0];
   assign ifc.traceFlow = q.psw[PSW_T1];
   assign ifc.superv = q.psw[PSW_S];
   assign ifc.source_space_select = q.source_space_select;
   assign ifc.dfc = q.dfc;
   assign ifc.instrDone = instrDone;
   assign ifc.flowInstr = flowInstr;
   assign ifc.cycReq = cycReq;
   assign ifc.cycProg = cycProg;
   assign ifc.cycAlt = cycAlt;
   assign ifc.cycDst = cycDst;

   cprs_space_trace u_space_trace (
      .clock(clock),
      .rst(rst),
      .ifc(ifc.unit)
   );

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign rdData = q.rdData;
   assign ixValue = q.ixValue;
   assign vecAddr = q.vecAddr;
   assign spaceCodeLines = ifc.spaceCode;
   assign traceTrap = ifc.traceTrap;
   assign supervisor = q.psw[PSW_S];
   assign intPrioMask = q.psw[PSW_IPM+2:PSW_IPM];
   assign icacheCtl = q.ictl;
   assign icacheAddr = q.iadr;
   assign irq = q.irq;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   AST_INDEX_SCALE: assert property (
      ixLong && ixIdx != SP_IDX |=> ixValue == ($past(q.gpr[ixIdx]) << $past(ixScale)))
      else $error("scaled index wrong");
   AST_QUAD_PAIR: assert property (
      wrEn && wrSize == SZ_QUAD && wrIdx == 4'h2 && !bfEn && !wrTake
      |=> q.gpr[3] == $past(wrData[63:32]) && q.gpr[2] == $past(wrData[31:0]))
      else $error("quad pair not stored");
   AST_ADDR_SIZE: assert property (wrEn && wrIdx[3] && wrSize == SZ_BYTE |=> q.ist[IRQ_SIZE])
      else $error("byte write to address register not refused");
   // Narrow writes: address registers widen by sign, fields leave their neighbours alone
   AST_WORD_SEXT: assert property (
      wrEn && wrIdx == 4'h9 && wrSize == SZ_WORD && !bfEn && !wrTake
      |=> q.gpr[9] == {{16{$past(wrData[15])}}, $past(wrData[15:0])})
      else $error("word write to address register not sign extended");
   AST_FIELD_KEEP: assert property (
      bfEn && bfIdx == 3'h0 && bfWid == 5'h8 && bfOff == 5'h4 && !wrEn && !wrTake
      |=> q.gpr[0][31:12] == $past(q.gpr[0][31:12]) && q.gpr[0][3:0] == $past(q.gpr[0][3:0])
      && q.gpr[0][11:4] == $past(bfData[7:0]))
      else $error("bit field insert wrong or disturbed neighbours");
   AST_PSW_RESERVED: assert property ((q.psw & ~PSW_IMPL) == 16'h0)
      else $error("reserved status bits set");
   AST_CC_UPDATE: assert property (ccEn && !pswWrTake |=> q.psw[4:0] == $past(ccIn))
      else $error("condition flags not updated");
   AST_VEC_BASE: assert property (##1 vecAddr == $past(q.vbr) + {22'h0, $past(vecNum), 2'b00})
      else $error("vector address wrong");
   AST_SP_ACTIVE: assert property (
      rdIdx == SP_IDX && q.psw[PSW_S] && q.psw[PSW_M] |=> rdData == $past(q.msp))
      else $error("master stack pointer not selected");
   AST_IRQ_LEVEL: assert property (q.ist[IRQ_TRACE] && q.imask[IRQ_TRACE] |-> irq)
      else $error("interrupt not raised");

endmodule
`default_nettype wire

// [cprs_space_trace.sv]
`timescale 1ns/1ps
`default_nettype none
module cprs_space_trace
   import cprs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   cprs_core_if.unit ifc
);

   typedef struct packed {
      logic trap;
      logic [2:0] code;
   } cprs_unit_s;

   cprs_unit_s q;
   cprs_unit_s n;

   // ---------------------------------------------------------------
   // Trace trap and space code
   // ---------------------------------------------------------------
   // Code holds between cycles so the memory side sees a stable value
   always_comb begin
      n = q;
      n.trap = ifc.instrDone && ifc.traceEvery;
      if (ifc.instrDone && ifc.traceFlow && ifc.flowInstr) begin
         n.trap = 1'b1;
      end
      if (ifc.cycReq) begin
         if (ifc.cycAlt) begin
            n.code = ifc.cycDst ? ifc.dfc : ifc.source_space_select;
         end else if (ifc.superv) begin
            n.code = ifc.cycProg ? SPC_SUP_PROG : SPC_SUP_DATA;
         end else begin
            n.code = ifc.cycProg ? SPC_USER_PROG : SPC_USER_DATA;
         end
      end
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '{trap: 1'b0, code: SPC_SUP_PROG};
      end else begin
         q <= n;
      end
   end

   assign ifc.traceTrap = q.trap;
   assign ifc.spaceCode = q.code;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   AST_TRACE_EVERY: assert property (ifc.instrDone && ifc.traceEvery |=> ifc.traceTrap)
      else $error("trace trap missing after instruction");
   AST_TRACE_FLOW: assert property (
      ifc.instrDone && !ifc.traceEvery && ifc.traceFlow |=> ifc.traceTrap == $past(ifc.flowInstr))
      else $error("flow trace trap wrong");
   AST_SPACE_SUP: assert property (
      ifc.cycReq && !ifc.cycAlt && ifc.superv && ifc.cycProg |=> ifc.spaceCode == SPC_SUP_PROG)
      else $error("supervisor program code wrong");
   AST_ALT_DEST: assert property (
      ifc.cycReq && ifc.cycAlt && ifc.cycDst |=> ifc.spaceCode == $past(ifc.dfc)
      ##1 ($past(ifc.cycReq) || $stable(ifc.spaceCode)))
      else $error("alternate destination code not held");

endmodule
`default_nettype wire

// [cpu_programmer_register_set_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_programmer_register_set_test;
   import cprs_pkg::*;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, ev;
   logic [7:0] paddr, vecNum;
   logic [31:0] pwdata, prdata, rdData, ixValue, vecAddr, icacheCtl, icacheAddr, bfData, rv;
   logic wrEn, bfEn, ccEn, ixLong, instrDone, flowInstr, cycReq, cycProg, cycAlt, cycDst;
   logic traceTrap, supervisor, irq, supArea, refuse;
   logic [3:0] wrIdx, rdIdx, ixIdx;
   logic [1:0] wrSize, ixScale;
   logic [63:0] wrData;
   logic [2:0] bfIdx, spaceCodeLines, intPrioMask;
   logic [4:0] bfOff, bfWid, ccIn;
   int n_fail = 0;
   int cmp_count = 0;

   // ---------------------------------------------------------------
   // Block under test and memory side
   // ---------------------------------------------------------------
   cprs_regset dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wrEn(wrEn), .wrIdx(wrIdx), .wrSize(wrSize), .wrData(wrData),
      .bfEn(bfEn), .bfIdx(bfIdx), .bfOff(bfOff), .bfWid(bfWid), .bfData(bfData),
      .ccEn(ccEn), .ccIn(ccIn), .rdIdx(rdIdx), .rdData(rdData), .ixIdx(ixIdx),
      .ixLong(ixLong), .ixScale(ixScale), .ixValue(ixValue), .vecNum(vecNum),
      .vecAddr(vecAddr), .instrDone(instrDone), .flowInstr(flowInstr), .cycReq(cycReq),
      .cycProg(cycProg), .cycAlt(cycAlt), .cycDst(cycDst), .spaceCodeLines(spaceCodeLines),
      .traceTrap(traceTrap), .supervisor(supervisor), .intPrioMask(intPrioMask),
      .icacheCtl(icacheCtl), .icacheAddr(icacheAddr), .irq(irq));
   cprs_mem_model mem_u (.clock(clock), .rst(rst), .cycReq(cycReq),
      .spaceCode(spaceCodeLines), .supArea(supArea), .refuse_q(refuse));

   // Free running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Request held until pready seen; one idle edge after release
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      // Looked at on the rising edge itself, so the value seen is the one held before that edge
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask

   task automatic core(input logic [3:0] i, input logic [1:0] s, input logic [63:0] d);
      wrEn <= 1'b1;
      wrIdx <= i;
      wrSize <= s;
      wrData <= d;
      @(posedge clock);
      wrEn <= 1'b0;
      @(posedge clock);
   endtask

   task automatic instr(input logic flow, input logic exp);
      instrDone <= 1'b1;
      flowInstr <= flow;
      @(posedge clock);
      instrDone <= 1'b0;
      flowInstr <= 1'b0;
      @(negedge clock);
      chk(traceTrap, exp);
      @(posedge clock);
   endtask

   // Space code one cycle after request, memory verdict a cycle later
   task automatic spc(input logic p, a, ds, ar, input logic [2:0] exp, input logic eRef);
      cycReq <= 1'b1;
      cycProg <= p;
      cycAlt <= a;
      cycDst <= ds;
      supArea <= ar;
      @(posedge clock);
      cycReq <= 1'b0;
      @(negedge clock);
      chk(spaceCodeLines, exp);
      @(posedge clock);
      @(negedge clock);
      chk(refuse, eRef);
      @(posedge clock);
   endtask

   // ---------------------------------------------------------------
   // Main sequence, every step aligned just after a rising edge
   // ---------------------------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, wrEn, bfEn, ccEn, ixLong, instrDone, flowInstr} = 10'h200;
      {cycReq, cycProg, cycAlt, cycDst, supArea} = '0;
      {paddr, vecNum, pwdata, bfData, wrIdx, rdIdx, ixIdx, wrSize, ixScale} = '0;
      {wrData, bfIdx, bfOff, bfWid, ccIn} = '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(supervisor, 1'b1);
      chk(intPrioMask, 3'h7);
      rd(OFF_PSW, 32'h2700);
      // Fifteen general registers, index use of a long register
      for (int i = 0; i < 15; i++) apb(1'b1, 8'(i * 4), 32'h11110000 + i);
      for (int i = 0; i < 15; i++) rd(8'(i * 4), 32'h11110000 + i);
      ixIdx <= 4'h3;
      ixLong <= 1'b1;
      ixScale <= 2'h3;
      @(posedge clock);
      @(negedge clock);
      chk(ixValue, 32'h88880018);
      @(posedge clock);
      apb(1'b1, 8'h6c, 32'h5);
      chk(ev, 1'b1);
      // Active stack pointer follows the privilege and master bits
      apb(1'b1, OFF_USP, 32'ha0);
      apb(1'b1, OFF_ISP, 32'hb0);
      apb(1'b1, OFF_MSP, 32'hc0);
      rd(8'h3c, 32'hb0);
      rdIdx <= SP_IDX;
      apb(1'b1, OFF_PSW, 32'h3700);
      rd(8'h3c, 32'hc0);
      chk(rdData, 32'hc0);
      apb(1'b1, OFF_PSW, 32'h0700);
      rd(8'h3c, 32'ha0);
      apb(1'b1, OFF_PSW, 32'h2700);
      // Core writes: quad pair, byte merge, word extension, refusal
      core(4'h2, SZ_QUAD, 64'h0123456789abcdef);
      rd(8'h08, 32'h89abcdef);
      rd(8'h0c, 32'h01234567);
      rdIdx <= 4'h3;
      @(posedge clock);
      @(negedge clock);
      chk(rdData, 32'h01234567);
      @(posedge clock);
      core(4'h4, SZ_BYTE, 64'hff);
      rd(8'h10, 32'h111100ff);
      core(4'h9, SZ_WORD, 64'h8001);
      rd(8'h24, 32'hffff8001);
      core(4'ha, SZ_BYTE, 64'h77);
      rd(8'h28, 32'h1111000a);
      rd(OFF_IST, 32'h2);
      chk(irq, 1'b0);
      apb(1'b1, OFF_IMASK, 32'h2);
      @(negedge clock);
      chk(irq, 1'b1);
      @(posedge clock);
      apb(1'b1, OFF_IST, 32'h2);
      @(negedge clock);
      chk(irq, 1'b0);
      @(posedge clock);
      // Bit field insert
      bfEn <= 1'b1;
      bfOff <= 5'h4;
      bfWid <= 5'h8;
      bfData <= 32'hff;
      @(posedge clock);
      bfEn <= 1'b0;
      @(posedge clock);
      rd(8'h00, 32'h11110ff0);
      // Condition flags and status word fields
      ccEn <= 1'b1;
      ccIn <= 5'h15;
      @(posedge clock);
      ccEn <= 1'b0;
      @(posedge clock);
      rd(OFF_PSW, 32'h2715);
      apb(1'b1, OFF_PSW, 32'hffff);
      rd(OFF_PSW, {16'h0, PSW_IMPL});
      apb(1'b1, OFF_PSW, 32'h0200);
      @(negedge clock);
      chk({supervisor, intPrioMask}, 4'h2);
      @(posedge clock);
      // Trace on every instruction, then on flow changes only
      apb(1'b1, OFF_PSW, 32'h6700);
      instr(1'b0, 1'b1);
      apb(1'b1, OFF_PSW, 32'ha700);
      instr(1'b0, 1'b0);
      instr(1'b1, 1'b1);
      apb(1'b1, OFF_PSW, 32'h2700);
      instr(1'b1, 1'b0);
      rd(OFF_IST, 32'h1);
      // Vector base and cache registers
      apb(1'b1, OFF_VBR, 32'h1000);
      vecNum <= 8'hff;
      apb(1'b1, OFF_ICTL, 32'h89abcdef);
      apb(1'b1, OFF_IADR, 32'h12345678);
      @(negedge clock);
      chk(vecAddr, 32'h13fc);
      chk({icacheCtl, icacheAddr}, 64'h89abcdef12345678);
      @(posedge clock);
      // Space codes, alternate registers and the memory verdict
      apb(1'b1, OFF_SFC, 32'h2);
      apb(1'b1, OFF_DFC, 32'h1);
      rd(OFF_SFC, 32'h2);
      spc(1'b1, 1'b0, 1'b0, 1'b1, SPC_SUP_PROG, 1'b0);
      spc(1'b0, 1'b0, 1'b0, 1'b1, SPC_SUP_DATA, 1'b0);
      spc(1'b0, 1'b1, 1'b0, 1'b0, SPC_USER_PROG, 1'b0);
      spc(1'b0, 1'b1, 1'b1, 1'b1, SPC_USER_DATA, 1'b1);
      apb(1'b1, OFF_PSW, 32'h0700);
      spc(1'b1, 1'b0, 1'b0, 1'b1, SPC_USER_PROG, 1'b1);
      spc(1'b0, 1'b0, 1'b0, 1'b0, SPC_USER_DATA, 1'b0);
      print_verdict();
   end

   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (50000) @(posedge clock);
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
